// ### ack_pkg.sv
package ack_pkg;
  // Timing
  localparam int CLK_NS     = 8;
  localparam int SEC_NS     = 1_000_000_000;
  localparam int TICK_CYC   = SEC_NS / CLK_NS;
  localparam int WINDOW_S   = 30;
  localparam int STEP0_S    = 1;
  localparam int STEP1_S    = 5;
  localparam int STEP2_S    = 20;
  localparam int HIST_DEPTH = 100;
  // Interval level at which automatic acknowledgement stops
  localparam logic [1:0] LVL_ENDLESS = 2'h3;
  // Acknowledge type codes
  typedef enum logic [1:0] {
    ACK_SELF = 2'h0, ACK_CFG = 2'h1, ACK_PART = 2'h2, ACK_MANUAL = 2'h3
  } ack_type_t;
  // Relay source codes
  typedef enum logic [1:0] {
    RLY_NONE = 2'h0, RLY_ALERT = 2'h1, RLY_WARN = 2'h2, RLY_ANY = 2'h3
  } relay_src_t;
  // Register offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_ACK    = 8'h04;
  localparam logic [7:0] OFS_TYPE   = 8'h08;
  localparam logic [7:0] OFS_AUTO   = 8'h0c;
  localparam logic [7:0] OFS_CLASS  = 8'h10;
  localparam logic [7:0] OFS_RELAY  = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_MAIN   = 8'h1c;
  localparam logic [7:0] OFS_HSEL   = 8'h20;
  localparam logic [7:0] OFS_HID    = 8'h24;
  localparam logic [7:0] OFS_HCOME  = 8'h28;
  localparam logic [7:0] OFS_HGONE  = 8'h2c;
  localparam logic [7:0] OFS_LEVEL  = 8'h30;
  localparam logic [7:0] OFS_TIME   = 8'h34;
  // Field positions
  localparam int CTRL_DI_EN = 3;
  localparam int CTRL_CLR   = 8;
  localparam int ST_ACKED   = 8;
  localparam int ST_CAME    = 16;
  localparam int MN_VALID   = 8;
  localparam int MN_ALERT   = 9;
  localparam int MN_FAULT   = 16;
  localparam int MN_WARN    = 17;
  localparam int HID_CNT    = 8;
  localparam int HID_VALID  = 31;
  // Reset values
  localparam logic [3:0]  CTRL_RST  = 4'h9;
  localparam logic [15:0] TYPE_RST  = 16'h0000;
  localparam logic [7:0]  AUTO_RST  = 8'h00;
  localparam logic [7:0]  CLASS_RST = 8'h00;
  localparam logic [31:0] RELAY_RST = 32'h0000_0001;
endpackage

// ### msg_tracker.sv
module msg_tracker (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // Time base and timer clear
  input  wire logic        tick_i,
  input  wire logic        clr_i,
  input  wire logic [31:0] now_i,
  // Condition and settings
  input  wire logic        cond_i,
  input  wire logic [1:0]  type_i,
  input  wire logic        auto_i,
  // Acknowledge and history handshake
  input  wire logic        ack_i,
  input  wire logic        ret_gnt_i,
  output logic             ret_req_o,
  // Message state
  output logic             came_o,
  output logic             acked_o,
  output logic             rise_o,
  output logic [31:0]      come_o,
  output logic [31:0]      gone_o,
  output logic [1:0]       level_o
);
  if (ack_pkg::WINDOW_S > 31 || ack_pkg::STEP2_S > 31) begin : g_bad
    $error("msg_tracker: timer too wide");
  end

  logic        cond_q, came_q, acked_q, ivl_run_q, win_run_q;
  logic [31:0] come_q, gone_q;
  logic [1:0]  level_q;
  logic [4:0]  ivl_q, win_q;

  // Interval length in seconds for each level
  function automatic logic [4:0] step_len(input logic [1:0] lvl);
    return (lvl == 2'h0) ? 5'(ack_pkg::STEP0_S) :
           (lvl == 2'h1) ? 5'(ack_pkg::STEP1_S) : 5'(ack_pkg::STEP2_S);
  endfunction

  // Edges, acknowledge causes and timer expiry
  ack_pkg::ack_type_t kind_w;
  assign kind_w = ack_pkg::ack_type_t'(type_i);
  wire rise_w  = cond_i & ~cond_q;
  wire fall_w  = ~cond_i & cond_q;
  wire part_w  = kind_w == ack_pkg::ACK_PART;
  wire recur_w = rise_w & win_run_q & part_w;
  wire ivl_exp = ivl_run_q & tick_i & (ivl_q == 5'h01);
  wire win_exp = win_run_q & tick_i & (win_q == 5'h01) & ~rise_w;
  wire open_w  = came_q & ~cond_i & ~acked_q;
  wire man_ok  = ack_i & open_w;
  wire self_w  = kind_w == ack_pkg::ACK_SELF;
  wire cfg_w   = (kind_w == ack_pkg::ACK_CFG) & auto_i;
  wire auto_ok = open_w & (self_w | cfg_w | (part_w & ivl_exp));

  // Occurrence, acknowledge and time stamps
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cond_q  <= 1'b0;
      came_q  <= 1'b0;
      acked_q <= 1'b0;
      come_q  <= 32'h0;
      gone_q  <= 32'h0;
    end else begin
      cond_q <= cond_i;
      if (rise_w & ~came_q) begin
        came_q <= 1'b1;
        come_q <= now_i;
      end else if (ret_gnt_i) begin
        came_q <= 1'b0;
      end
      if (fall_w) gone_q <= now_i;
      if (man_ok | auto_ok) acked_q <= 1'b1;
      else if (ret_gnt_i) acked_q <= 1'b0;
    end
  end

  // Interval level: up on recurrence, down when the window passes quietly
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) level_q <= 2'h0;
    else if (clr_i) level_q <= 2'h0;
    else if (man_ok && level_q == ack_pkg::LVL_ENDLESS) level_q <= 2'h0;
    else if (recur_w && level_q != ack_pkg::LVL_ENDLESS) level_q <= level_q + 2'h1;
    else if (win_exp && level_q != 2'h0 && level_q != ack_pkg::LVL_ENDLESS) begin
      level_q <= level_q - 2'h1;
    end
  end

  // Interval timer, started when the alert clears
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ivl_run_q <= 1'b0;
      ivl_q     <= 5'h00;
    end else if (clr_i || recur_w) begin
      ivl_run_q <= 1'b0;
    end else if (fall_w && part_w && level_q != ack_pkg::LVL_ENDLESS) begin
      ivl_run_q <= 1'b1;
      ivl_q     <= step_len(level_q);
    end else if (ivl_run_q && tick_i) begin
      ivl_q <= ivl_q - 5'h01;
      if (ivl_q == 5'h01) ivl_run_q <= 1'b0;
    end
  end

  // Recurrence window, rearmed while a step back is still possible
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      win_run_q <= 1'b0;
      win_q     <= 5'h00;
    end else if (clr_i || recur_w) begin
      win_run_q <= 1'b0;
    end else if (fall_w && part_w) begin
      win_run_q <= 1'b1;
      win_q     <= 5'(ack_pkg::WINDOW_S);
    end else if (win_exp) begin
      win_run_q <= (level_q == 2'h2);
      win_q     <= 5'(ack_pkg::WINDOW_S);
    end else if (win_run_q && tick_i) begin
      win_q <= win_q - 5'h01;
    end
  end

  // Outputs
  assign ret_req_o = came_q & acked_q & ~cond_i;
  assign came_o    = came_q;
  assign acked_o   = acked_q;
  assign rise_o    = rise_w;
  assign come_o    = come_q;
  assign gone_o    = gone_q;
  assign level_o   = level_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_step_up;
    recur_w && !clr_i && level_q != ack_pkg::LVL_ENDLESS |=> level_q == $past(level_q) + 2'h1;
  endproperty
  a_step_up: assert property (p_step_up) else $error("level not advanced");
  property p_step_back;
    win_exp && level_q == 2'h2 && !clr_i |=> level_q == 2'h1 && win_run_q && win_q == 5'h1e;
  endproperty
  a_step_back: assert property (p_step_back) else $error("no step back");
  property p_ivl_len;
    fall_w && part_w && !clr_i && level_q != ack_pkg::LVL_ENDLESS |=> ivl_run_q &&
      ivl_q == ($past(level_q) == 2'h0 ? 5'h01 : $past(level_q) == 2'h1 ? 5'h05 : 5'h14);
  endproperty
  a_ivl_len: assert property (p_ivl_len) else $error("wrong interval");
  property p_endless;
    level_q == ack_pkg::LVL_ENDLESS && !ack_i && !clr_i |=> level_q == ack_pkg::LVL_ENDLESS && !ivl_run_q;
  endproperty
  a_endless: assert property (p_endless) else $error("endless step left");
  property p_self;
    open_w && self_w |=> acked_q;
  endproperty
  a_self: assert property (p_self) else $error("self ack missing");
  property p_manual;
    !acked_q && !ack_i && (kind_w == ack_pkg::ACK_MANUAL || kind_w == ack_pkg::ACK_CFG && !auto_i)
      |=> !acked_q;
  endproperty
  a_manual: assert property (p_manual) else $error("unrequested ack");
  property p_come;
    rise_w && came_q |=> come_q == $past(come_q);
  endproperty
  a_come: assert property (p_come) else $error("come stamp moved");
  property p_gone;
    fall_w |=> gone_q == $past(now_i);
  endproperty
  a_gone: assert property (p_gone) else $error("gone stamp stale");
  c_endless: cover property (recur_w && level_q == 2'h2);
endmodule

// ### ack_manager.sv
// Behaviour
// - Acknowledged messages still present stay in the pending list.
// - Only messages that came, were acknowledged and went enter the history.
// - History keeps the 100 newest entries, dropping the oldest when full.
// - Main indication shows the most recently received message.
// - Acknowledge accepted only after the cause is gone; single messages addressable.
// - A digital input can acknowledge; input two by default.
// - Self-acknowledging messages acknowledge once their condition is gone.
// - Configurable messages choose automatic or manual acknowledgement per message.
// - Partially automatic alerts start the interval on clearing, acknowledge on expiry.
// - Recurrence within thirty seconds of interval start advances one step.
// - No recurrence in thirty seconds steps back; evaluated again thirty seconds later.
// - Interval steps are one, five, twenty seconds, then endless.
// - After the twenty-second step is extended, only manual acknowledge is possible.
// - Messages without automatic acknowledgement wait for a manual request.
// - Come stamp keeps the first occurrence while unacknowledged.
// - Gone stamp follows every clearing of the condition.
// - Alert and warning states route to relays by a configurable assignment.
// - An active alert takes precedence over warnings in the indication.
// - An active alert means fault standstill; a warning leaves the drive running.
//
// Design decisions made here: the APB slave port and the address map.
module ack_manager #(
  parameter int NUM_MSG   = 8,
  parameter int NUM_DI    = 8,
  parameter int NUM_RELAY = 2,
  parameter int TICK_CYC  = ack_pkg::TICK_CYC
) (
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 reset_n_i,
  // APB slave
  input  wire logic                 psel_i,
  input  wire logic                 penable_i,
  input  wire logic                 pwrite_i,
  input  wire logic [7:0]           paddr_i,
  input  wire logic [31:0]          pwdata_i,
  output logic      [31:0]          prdata_o,
  output logic                      pready_o,
  output logic                      pslverr_o,
  // Message conditions and digital inputs
  input  wire logic [NUM_MSG-1:0]   msg_cond_i,
  input  wire logic [NUM_DI-1:0]    di_i,
  // Indication and relays
  output logic      [NUM_MSG-1:0]   pending_o,
  output logic      [2:0]           main_idx_o,
  output logic                      main_valid_o,
  output logic                      fault_o,
  output logic                      warning_o,
  output logic      [NUM_RELAY-1:0] relay_o
);
  if (NUM_MSG < 1 || NUM_MSG > 8 || NUM_DI < 2 || NUM_DI > 8 || NUM_RELAY < 1 ||
      NUM_RELAY > 16 || TICK_CYC < 2) begin : g_bad
    $error("ack_manager: unsupported parameter");
  end

  localparam int TW = $clog2(TICK_CYC);
  localparam int HD = ack_pkg::HIST_DEPTH;

  // Lowest set bit of a message vector
  function automatic logic [2:0] first_idx(input logic [7:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 7; i >= 0; i--) if (v[i]) r = 3'(i);
    return r;
  endfunction

  // Relay source decode
  function automatic logic relay_pick(input logic [1:0] s, input logic a, input logic w);
    unique case (ack_pkg::relay_src_t'(s))
      ack_pkg::RLY_NONE:  return 1'b0;
      ack_pkg::RLY_ALERT: return a;
      ack_pkg::RLY_WARN:  return w;
      ack_pkg::RLY_ANY:   return a | w;
    endcase
  endfunction

  logic [TW-1:0]      div_q;
  logic               tick_q;
  logic [31:0]        now_q, prdata_q;
  logic               pslverr_q;
  logic [3:0]         ctrl_q;
  logic [15:0]        type_q;
  logic [7:0]         auto_q, class_q, di_q;
  logic [31:0]        relay_q;
  logic [6:0]         hsel_q, wr_ptr_q, hcnt_q;
  logic [2:0]         last_idx_q, last_alert_q;
  logic [NUM_MSG-1:0] came_v, acked_v, rise_v, ret_v, gnt_v, ack_v;
  logic [31:0]        come_a [NUM_MSG];
  logic [31:0]        gone_a [NUM_MSG];
  logic [1:0]         lvl_a [NUM_MSG];
  logic [15:0]        lvl_w;
  logic [2:0]         hid_a [HD];
  logic [31:0]        hcome_a [HD];
  logic [31:0]        hgone_a [HD];

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire       setup_w  = psel_i & ~penable_i;
  wire       wr_w     = psel_i & penable_i & pwrite_i;
  wire       h_ctrl   = paddr_i == ack_pkg::OFS_CTRL;
  wire       h_ack    = paddr_i == ack_pkg::OFS_ACK;
  wire       h_type   = paddr_i == ack_pkg::OFS_TYPE;
  wire       h_auto   = paddr_i == ack_pkg::OFS_AUTO;
  wire       h_class  = paddr_i == ack_pkg::OFS_CLASS;
  wire       h_relay  = paddr_i == ack_pkg::OFS_RELAY;
  wire       h_status = paddr_i == ack_pkg::OFS_STATUS;
  wire       h_main   = paddr_i == ack_pkg::OFS_MAIN;
  wire       h_hsel   = paddr_i == ack_pkg::OFS_HSEL;
  wire       h_hid    = paddr_i == ack_pkg::OFS_HID;
  wire       h_hcome  = paddr_i == ack_pkg::OFS_HCOME;
  wire       h_hgone  = paddr_i == ack_pkg::OFS_HGONE;
  wire       h_level  = paddr_i == ack_pkg::OFS_LEVEL;
  wire       h_time   = paddr_i == ack_pkg::OFS_TIME;
  wire       hit_w    = h_ctrl | h_ack | h_type | h_auto | h_class | h_relay | h_status |
                        h_main | h_hsel | h_hid | h_hcome | h_hgone | h_level | h_time;
  wire       clr_w    = wr_w & h_ctrl & pwdata_i[ack_pkg::CTRL_CLR];

  // Acknowledge requests: one message from software, all from the input
  wire [7:0] di_pad   = 8'(di_i);
  wire       di_edge  = ctrl_q[ack_pkg::CTRL_DI_EN] & di_pad[ctrl_q[2:0]] & ~di_q[ctrl_q[2:0]];
  assign ack_v = {NUM_MSG{di_edge}} |
                 ({NUM_MSG{wr_w & h_ack}} & (NUM_MSG'(1) << pwdata_i[2:0]));

  // Indication and drive state
  wire [7:0] cond8    = 8'(msg_cond_i);
  wire [7:0] came8    = 8'(came_v);
  wire [7:0] alert8   = cond8 & class_q;
  wire       alert_w  = |alert8;
  wire       warn_w   = |(cond8 & ~class_q);
  wire [2:0] disp_w   = alert_w ? last_alert_q : last_idx_q;

  // History retirement and read pointer
  wire       ret_any  = |ret_v;
  wire [2:0] ret_idx  = first_idx(8'(ret_v));
  assign gnt_v = ret_any ? (NUM_MSG'(1) << ret_idx) : '0;
  wire [7:0] hraw_w   = 8'(wr_ptr_q) + 8'(HD - 1) - 8'(hsel_q);
  wire [7:0] hrd8_w   = (hraw_w >= 8'(HD)) ? hraw_w - 8'(HD) : hraw_w;
  wire [6:0] hrd_w    = hrd8_w[6:0];
  wire       hok_w    = hsel_q < hcnt_q;

  // Read data
  wire [31:0] st_w    = 32'(cond8) | (32'(8'(acked_v)) << ack_pkg::ST_ACKED) |
                        (32'(came8) << ack_pkg::ST_CAME);
  wire [31:0] mn_w    = 32'(main_idx_o) | (32'(main_valid_o) << ack_pkg::MN_VALID) |
                        (32'(alert_w) << ack_pkg::MN_ALERT) |
                        (32'(fault_o) << ack_pkg::MN_FAULT) | (32'(warning_o) << ack_pkg::MN_WARN);
  wire [31:0] hid_w   = hok_w ? (32'(hid_a[hrd_w]) | (32'h1 << ack_pkg::HID_VALID)) : 32'h0;
  wire [31:0] rd_w    = h_ctrl  ? 32'(ctrl_q) : h_type ? 32'(type_q) : h_auto ? 32'(auto_q) :
                        h_class ? 32'(class_q) : h_relay ? relay_q : h_status ? st_w :
                        h_main  ? mn_w : h_hsel ? 32'(hsel_q) :
                        h_hid   ? (hid_w | (32'(hcnt_q) << ack_pkg::HID_CNT)) :
                        h_hcome ? (hok_w ? hcome_a[hrd_w] : 32'h0) :
                        h_hgone ? (hok_w ? hgone_a[hrd_w] : 32'h0) :
                        h_level ? 32'(lvl_w) : h_time ? now_q : 32'h0;

  ////////////////////////////////////////////////////////////////////////////
  // One-second tick and running seconds count
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_q  <= '0;
      tick_q <= 1'b0;
      now_q  <= 32'h0;
    end else if (clr_w) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= div_q == TW'(TICK_CYC - 1);
      div_q  <= (div_q == TW'(TICK_CYC - 1)) ? '0 : div_q + 1'b1;
      if (tick_q) now_q <= now_q + 32'h1;
    end
  end

  // APB registers; reads are captured in setup so the access phase never waits
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_q    <= ack_pkg::CTRL_RST;
      type_q    <= ack_pkg::TYPE_RST;
      auto_q    <= ack_pkg::AUTO_RST;
      class_q   <= ack_pkg::CLASS_RST;
      relay_q   <= ack_pkg::RELAY_RST;
      hsel_q    <= 7'h00;
      prdata_q  <= 32'h0;
      pslverr_q <= 1'b0;
    end else begin
      if (wr_w && h_ctrl) ctrl_q <= pwdata_i[3:0];
      if (wr_w && h_type) type_q <= pwdata_i[15:0];
      if (wr_w && h_auto) auto_q <= pwdata_i[7:0];
      if (wr_w && h_class) class_q <= pwdata_i[7:0];
      if (wr_w && h_relay) relay_q <= pwdata_i;
      if (wr_w && h_hsel) hsel_q <= pwdata_i[6:0];
      if (setup_w) begin
        prdata_q  <= pwrite_i ? 32'h0 : rd_w;
        pslverr_q <= ~hit_w;
      end
    end
  end

  // Message trackers
  for (genvar i = 0; i < NUM_MSG; i++) begin : g_msg
    msg_tracker u_trk (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .tick_i    (tick_q),
      .clr_i     (clr_w),
      .now_i     (now_q),
      .cond_i    (msg_cond_i[i]),
      .type_i    (type_q[2*i +: 2]),
      .auto_i    (auto_q[i]),
      .ack_i     (ack_v[i]),
      .ret_gnt_i (gnt_v[i]),
      .ret_req_o (ret_v[i]),
      .came_o    (came_v[i]),
      .acked_o   (acked_v[i]),
      .rise_o    (rise_v[i]),
      .come_o    (come_a[i]),
      .gone_o    (gone_a[i]),
      .level_o   (lvl_a[i])
    );
    assign lvl_w[2*i +: 2] = lvl_a[i];
  end
  if (NUM_MSG < 8) begin : g_lvl_pad
    assign lvl_w[15:2*NUM_MSG] = '0;
  end

  // History ring, one retirement per cycle, oldest overwritten when full
  always_ff @(posedge clk_i) begin
    if (ret_any) begin
      hid_a[wr_ptr_q]   <= ret_idx;
      hcome_a[wr_ptr_q] <= come_a[ret_idx];
      hgone_a[wr_ptr_q] <= gone_a[ret_idx];
    end
  end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr_q <= 7'h00;
      hcnt_q   <= 7'h00;
    end else if (ret_any) begin
      wr_ptr_q <= (wr_ptr_q == 7'(HD - 1)) ? 7'h00 : wr_ptr_q + 7'h01;
      if (hcnt_q != 7'(HD)) hcnt_q <= hcnt_q + 7'h01;
    end
  end

  // Latest message and latest alert, plus registered outputs
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      di_q         <= 8'h00;
      last_idx_q   <= 3'h0;
      last_alert_q <= 3'h0;
      pending_o    <= '0;
      main_idx_o   <= 3'h0;
      main_valid_o <= 1'b0;
      fault_o      <= 1'b0;
      warning_o    <= 1'b0;
      relay_o      <= '0;
    end else begin
      di_q <= di_pad;
      if (|rise_v) last_idx_q <= first_idx(8'(rise_v));
      if (|(8'(rise_v) & class_q)) last_alert_q <= first_idx(8'(rise_v) & class_q);
      pending_o    <= came_v;
      main_idx_o   <= disp_w;
      main_valid_o <= came8[disp_w];
      fault_o      <= alert_w;
      warning_o    <= warn_w;
      for (int r = 0; r < NUM_RELAY; r++) begin
        relay_o[r] <= relay_pick(relay_q[2*r +: 2], alert_w, warn_w);
      end
    end
  end

  assign prdata_o  = prdata_q;
  assign pslverr_o = pslverr_q;
  assign pready_o  = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_pending;
    came_v[0] && msg_cond_i[0] |=> pending_o[0];
  endproperty
  a_pending: assert property (p_pending) else $error("pending lost");
  property p_hist_src;
    ret_any |-> acked_v[ret_idx] && !msg_cond_i[ret_idx] ##1 !came_v[$past(ret_idx)];
  endproperty
  a_hist_src: assert property (p_hist_src) else $error("bad history entry");
  property p_hist_full;
    ret_any && hcnt_q == 7'h64 |=> hcnt_q == 7'h64 &&
      wr_ptr_q == ($past(wr_ptr_q) == 7'h63 ? 7'h00 : $past(wr_ptr_q) + 7'h01);
  endproperty
  a_hist_full: assert property (p_hist_full) else $error("history wrap");
  property p_latest;
    |rise_v |=> last_idx_q == $past(first_idx(8'(rise_v)));
  endproperty
  a_latest: assert property (p_latest) else $error("latest not shown");
  property p_ack_clear;
    ~|(acked_v & ~$past(acked_v) & $past(msg_cond_i));
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("ack while active");
  property p_di_ack;
    di_edge && came_v[0] && !acked_v[0] && !msg_cond_i[0] |=> acked_v[0];
  endproperty
  a_di_ack: assert property (p_di_ack) else $error("input ack ignored");
  property p_relay;
    relay_q[1:0] == 2'h1 |=> relay_o[0] == $past(alert_w);
  endproperty
  a_relay: assert property (p_relay) else $error("relay route");
  property p_alert_first;
    alert_w |=> main_idx_o == $past(last_alert_q) ##0 fault_o;
  endproperty
  a_alert_first: assert property (p_alert_first) else $error("alert not first");
  property p_tick;
    tick_q |=> !tick_q;
  endproperty
  a_tick: assert property (p_tick) else $error("tick too long");
  c_wrap:  cover property (ret_any && hcnt_q == 7'h64);
  c_di:    cover property (di_edge && |came_v);
  c_alert: cover property (alert_w && warn_w);
endmodule

// ### op_panel.sv
module op_panel (
  // Clock and key
  input  wire logic       clk_i,
  input  wire logic       key_i,
  // Digital input levels
  output logic      [7:0] di_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Acknowledge key drives the second input, others stay low
  always_ff @(posedge clk_i) di_o <= {6'h00, key_i, 1'b0};
endmodule

// ### tb_ack_manager.sv
module tb_ack_manager;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0, reset_n_i = 1'b0, key = 1'b0, er;
  logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00, cond = 8'h00, di, pending_o;
  logic [31:0] pwdata_i = 32'h0000_0000, prdata_o, rd;
  logic        pready_o, pslverr_o, main_valid_o, fault_o, warning_o;
  logic [2:0]  main_idx_o;
  logic [1:0]  relay_o;
  int          bad_count = 0, total_checks = 0;
  ack_manager #(.TICK_CYC(8)) dut (.clk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .msg_cond_i(cond), .di_i(di),
    .pending_o, .main_idx_o, .main_valid_o, .fault_o, .warning_o, .relay_o);
  op_panel panel (.clk_i, .key_i(key), .di_o(di));
  ////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial forever #4 clk_i = ~clk_i;
  initial begin
    #200000;
    bad_count++;
    finish_test();
  end
  // Shared checks and bus cycles
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Reset values and an unmapped place
  task automatic t_reset();
    apb(1'b0, ack_pkg::OFS_CTRL, 32'h0);
    check(rd, 32'h0000_0009);
    apb(1'b0, ack_pkg::OFS_RELAY, 32'h0);
    check(rd, 32'h0000_0001);
    apb(1'b0, 8'hfc, 32'h0);
    check({rd[30:0], er}, 32'h0000_0001);
  endtask
  // Self acknowledging message passes into history
  task automatic t_self();
    cond <= 8'h01;
    cyc(4);
    check({main_valid_o, main_idx_o, pending_o}, 32'h0801);
    cond <= 8'h00;
    cyc(5);
    check(pending_o, 8'h00);
    apb(1'b0, ack_pkg::OFS_HID, 32'h0);
    check(rd, 32'h8000_0100);
  endtask
  // Manual message, refused then accepted, and digital input acknowledge
  task automatic t_manual();
    apb(1'b1, ack_pkg::OFS_TYPE, 32'h0000_003c);
    cond <= 8'h06;
    cyc(3);
    apb(1'b1, ack_pkg::OFS_ACK, 32'h1);
    cyc(3);
    apb(1'b0, ack_pkg::OFS_STATUS, 32'h0);
    check(rd[15:8], 8'h00);
    cond <= 8'h00;
    cyc(40);
    check(pending_o, 8'h06);
    apb(1'b1, ack_pkg::OFS_ACK, 32'h1);
    cyc(5);
    check(pending_o, 8'h04);
    key <= 1'b1;
    cyc(1);
    key <= 1'b0;
    cyc(6);
    check(pending_o, 8'h00);
  endtask
  // Alert precedence, fault, relay routing
  task automatic t_alert();
    apb(1'b1, ack_pkg::OFS_CLASS, 32'h0000_0008);
    cond <= 8'h10;
    cyc(2);
    cond <= 8'h18;
    cyc(2);
    cond <= 8'h38;
    cyc(4);
    check({main_idx_o, fault_o, warning_o, relay_o}, 32'h0000_003d);
    cond <= 8'h30;
    cyc(4);
    check({main_idx_o, fault_o, relay_o}, 32'h0000_0028);
    cond <= 8'h00;
    cyc(8);
  endtask
  // Partially automatic alert: expiry, recurrence, longer interval
  task automatic t_part();
    apb(1'b1, ack_pkg::OFS_TYPE, 32'h0000_203c);
    cond <= 8'h40;
    cyc(3);
    cond <= 8'h00;
    cyc(24);
    check(pending_o, 8'h00);
    cond <= 8'h40;
    cyc(4);
    apb(1'b0, ack_pkg::OFS_LEVEL, 32'h0);
    check(rd, 32'h0000_1000);
    cond <= 8'h00;
    cyc(24);
    check(pending_o, 8'h40);
    cyc(32);
    check(pending_o, 8'h00);
    // Quiet window of thirty ticks steps the level back to the shortest interval
    cyc(200);
    apb(1'b0, ack_pkg::OFS_LEVEL, 32'h0);
    check(rd, 32'h0000_0000);
  endtask
  // Configurable message, manual then automatic, and other relay routings
  task automatic t_cfg();
    apb(1'b1, ack_pkg::OFS_TYPE, 32'h0000_603c);
    apb(1'b1, ack_pkg::OFS_RELAY, 32'h0000_000e);
    cond <= 8'h80;
    cyc(3);
    check(relay_o, 32'h0000_0003);
    cond <= 8'h00;
    cyc(6);
    check(pending_o, 8'h80);
    apb(1'b1, ack_pkg::OFS_AUTO, 32'h0000_0080);
    cyc(5);
    check(pending_o, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    cyc(2);
    reset_n_i <= 1'b1;
    t_reset();
    t_self();
    t_manual();
    t_alert();
    t_part();
    t_cfg();
    finish_test();
  end
endmodule
